/* src/tpw_pkg.sv */
/*
 * Shared constants and types of the timer compare, PWM and interrupt
 * block: register indices, control and flag layouts, counter values.
 * Assumes an 8-bit register port with a 4-bit register index.
 */
`default_nettype none

package tpw_pkg;

    // ==========================================================
    // Register indices
    localparam logic [3:0] ADR_CTL_ONE = 4'h0;
    localparam logic [3:0] ADR_CTL_TWO = 4'h1;
    localparam logic [3:0] ADR_STATUS  = 4'h2;
    localparam logic [3:0] ADR_CAP1_HI = 4'h3;
    localparam logic [3:0] ADR_CAP1_LO = 4'h4;
    localparam logic [3:0] ADR_CMP1_HI = 4'h5;
    localparam logic [3:0] ADR_CMP1_LO = 4'h6;
    localparam logic [3:0] ADR_CMP2_HI = 4'h7;
    localparam logic [3:0] ADR_CMP2_LO = 4'h8;
    localparam logic [3:0] ADR_CNT_HI  = 4'h9;
    localparam logic [3:0] ADR_CNT_LO  = 4'hA;
    localparam logic [3:0] ADR_ALT_HI  = 4'hB;
    localparam logic [3:0] ADR_ALT_LO  = 4'hC;
    localparam logic [3:0] ADR_CAP2_HI = 4'hD;
    localparam logic [3:0] ADR_CAP2_LO = 4'hE;

    // ==========================================================
    // Values
    localparam logic [15:0] CNT_RESET  = 16'hFFFC;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;
    localparam logic [15:0] CMP_RESET  = 16'h8000;
    localparam logic [7:0]  RD_NONE    = 8'h00;
    localparam logic [2:0]  PRE_MASK_2 = 3'h1;
    localparam logic [2:0]  PRE_MASK_4 = 3'h3;
    localparam logic [2:0]  PRE_MASK_8 = 3'h7;

    // ==========================================================
    // Timer clock select
    typedef enum logic [1:0] {
        TPW_CS_DIV4 = 2'h0,
        TPW_CS_DIV2 = 2'h1,
        TPW_CS_DIV8 = 2'h2,
        TPW_CS_EXT  = 2'h3
    } tpw_clk_sel_t;

    // ==========================================================
    // Register layouts, bit 7 first
    typedef struct packed {
        logic capture_irq_enable;
        logic match_irq_enable;
        logic overflow_irq_enable;
        logic force_second_output;
        logic force_first_output;
        logic second_output_level;
        logic first_capture_edge_select;
        logic first_output_level;
    } tpw_ctl_one_t;

    typedef struct packed {
        logic         first_compare_pin_enable;
        logic         second_compare_pin_enable;
        logic         single_pulse_select;
        logic         pwm_select;
        tpw_clk_sel_t timer_clock_select;
        logic         second_capture_edge_select;
        logic         ext_clock_edge_select;
    } tpw_ctl_two_t;

    typedef struct packed {
        logic first_capture_flag;
        logic first_match_flag;
        logic overflow_flag;
        logic second_capture_flag;
        logic second_match_flag;
    } tpw_flags_t;

    // Synchronised pins: ext clock, capture 2, capture 1
    typedef struct packed {
        logic ext;
        logic cap2;
        logic cap1;
    } tpw_pins_t;

    typedef struct packed {
        tpw_ctl_one_t ctl1;
        tpw_ctl_two_t ctl2;
        tpw_flags_t   flg;
        tpw_flags_t   arm;
        logic         tdis;
        logic [15:0]  cnt;
        logic [2:0]   pre;
        logic [15:0]  cap1;
        logic [15:0]  cap2;
        logic [15:0]  cmp1;
        logic [15:0]  cmp2;
        logic [15:0]  sh1;
        logic [15:0]  sh2;
        logic         lock1;
        logic         lock2;
        tpw_pins_t    sy1;
        tpw_pins_t    sy2;
        tpw_pins_t    sy3;
        logic         halt_d;
        logic [1:0]   harm;
        logic         pin1;
        logic         pin2;
        logic         oe1;
        logic         oe2;
        logic [7:0]   rdata;
        logic         irq;
        logic         wwake;
    } tpw_state_t;

endpackage : tpw_pkg

`default_nettype wire

/* src/tpw_timer.sv */
/*
 * 16-bit timer with two captures, two compares, PWM and single-pulse
 * generation, power-state handling and one shared interrupt request.
 * Assumes CPU-clock register port (read data one cycle later) and
 * asynchronous pins that are synchronised here.
 */
// The plain strobed port and the address map are this design's own decisions.
// Function
// - PWM with level1 high, level2 low: high pulse of compare2 minus compare1
// - PWM with equal levels: compare-1 pin stays constant
// - PWM period equals compare-2 value plus 5 timer ticks; level-2 part compare-1 value plus 5
// - PWM: compare-2 match reloads counter with FFFC
// - PWM never sets either match flag
// - PWM: compare-2 match sets capture flag 1
// - PWM disconnects capture pin 1; capture 2 still works
// - PWM and single pulse both set: PWM only
// - Wait leaves timer running; enabled interrupt wakes from wait
// - Halt freezes counter; halt exit resumes from frozen count
// - Capture edge during halt arms; capture at halt exit
// - Flags share their enables; wake wait, never halt
// - One interrupt request, gated by enable and CPU mask
// - Capture1 unavailable in PWM; compare1 unavailable in single-pulse and PWM
// - Three control/status registers and six 16-bit data pairs
// - Bit 7 enables capture flag interrupts
// - Bit 6 enables match flag interrupts
// - Bit 5 enables overflow interrupt
// - Force bits copy output levels to enabled compare pins outside PWM and single pulse
// - Level2 drives compare-2 pin, or compare-1 pin in PWM/single
// - Bit 1 picks capture-1 edge: 0 falling, 1 rising
// - Level1 drives compare-1 pin on first-compare match
// - Clock select: /4, /2, /8, external clock
// - PWM compare values move to shadows only at period end
// - Overflow flag on counter roll from FFFF to 0000
`timescale 1ns/1ps
`default_nettype none

module tpw_timer
    import tpw_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    // Register port
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output var  logic [7:0] o_rdata,
    // CPU power state and mask
    input  wire logic       i_wait,
    input  wire logic       i_halt,
    input  wire logic       i_irq_mask,
    // Pins
    input  wire logic       i_first_capture_pin,
    input  wire logic       i_second_capture_pin,
    input  wire logic       i_ext_clk,
    output var  logic       o_first_compare_pin,
    output var  logic       o_first_compare_pin_oe,
    output var  logic       o_second_compare_pin,
    output var  logic       o_second_compare_pin_oe,
    // Interrupt
    output var  logic       o_irq,
    output var  logic       o_wait_wake
);

    // ==========================================================
    // State
    tpw_state_t r;
    tpw_state_t n;

    logic       pwm_on;
    logic       single_on;
    logic       run;
    logic       tick;
    logic       m1;
    logic       m2;
    logic       cap1_ev;
    logic       cap2_ev;
    logic       ext_ev;
    logic       halt_exit;
    logic [2:0] pre_mask;
    tpw_pins_t  rise;
    tpw_pins_t  fall;
    logic [7:0] rd_mux;

    // ==========================================================
    // Events
    always_comb begin
        pwm_on    = r.ctl2.pwm_select;
        single_on = r.ctl2.single_pulse_select && !pwm_on;
        run       = !i_halt && !r.tdis;
        rise      = r.sy2 & ~r.sy3;
        fall      = ~r.sy2 & r.sy3;
        cap1_ev   = r.ctl1.first_capture_edge_select
                    ? rise.cap1 : fall.cap1;
        cap2_ev   = r.ctl2.second_capture_edge_select
                    ? rise.cap2 : fall.cap2;
        ext_ev    = r.ctl2.ext_clock_edge_select
                    ? rise.ext : fall.ext;
        halt_exit = r.halt_d && !i_halt;
        unique case (r.ctl2.timer_clock_select)
            TPW_CS_DIV4: pre_mask = PRE_MASK_4;
            TPW_CS_DIV2: pre_mask = PRE_MASK_2;
            TPW_CS_DIV8: pre_mask = PRE_MASK_8;
            TPW_CS_EXT:  pre_mask = PRE_MASK_8;
        endcase
        if (r.ctl2.timer_clock_select == TPW_CS_EXT) begin
            tick = run && ext_ev;
        end else begin
            tick = run && ((r.pre & pre_mask) == pre_mask);
        end
        m1 = tick && (r.cnt == r.sh1) && (pwm_on || !r.lock1);
        m2 = tick && (r.cnt == r.sh2) && (pwm_on || !r.lock2);
    end

    // ==========================================================
    // Read mux
    always_comb begin
        unique case (i_addr)
            ADR_CTL_ONE: rd_mux = r.ctl1;
            ADR_CTL_TWO: rd_mux = r.ctl2;
            ADR_STATUS:  rd_mux = {r.flg, r.tdis, 2'h0};
            ADR_CAP1_HI: rd_mux = r.cap1[15:8];
            ADR_CAP1_LO: rd_mux = r.cap1[7:0];
            ADR_CMP1_HI: rd_mux = r.cmp1[15:8];
            ADR_CMP1_LO: rd_mux = r.cmp1[7:0];
            ADR_CMP2_HI: rd_mux = r.cmp2[15:8];
            ADR_CMP2_LO: rd_mux = r.cmp2[7:0];
            ADR_CNT_HI:  rd_mux = r.cnt[15:8];
            ADR_CNT_LO:  rd_mux = r.cnt[7:0];
            ADR_ALT_HI:  rd_mux = r.cnt[15:8];
            ADR_ALT_LO:  rd_mux = r.cnt[7:0];
            ADR_CAP2_HI: rd_mux = r.cap2[15:8];
            ADR_CAP2_LO: rd_mux = r.cap2[7:0];
            default:     rd_mux = RD_NONE;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        n        = r;
        n.sy1    = '{ext: i_ext_clk, cap2: i_second_capture_pin,
                     cap1: i_first_capture_pin};
        n.sy2    = r.sy1;
        n.sy3    = r.sy2;
        n.halt_d = i_halt;
        n.rdata  = i_rd ? rd_mux : RD_NONE;
        if (run) begin
            n.pre = r.pre + 3'h1;
        end

        // Flag clearing: status read arms, low-byte access clears
        if (i_rd && (i_addr == ADR_STATUS)) begin
            n.arm = r.arm | r.flg;
        end
        if ((i_rd || i_wr) && r.arm.first_capture_flag
            && (i_addr == ADR_CAP1_LO)) begin
            n.flg.first_capture_flag = 1'b0;
            n.arm.first_capture_flag = 1'b0;
        end
        if ((i_rd || i_wr) && r.arm.first_match_flag
            && (i_addr == ADR_CMP1_LO)) begin
            n.flg.first_match_flag = 1'b0;
            n.arm.first_match_flag = 1'b0;
        end
        if ((i_rd || i_wr) && r.arm.overflow_flag
            && (i_addr == ADR_CNT_LO)) begin
            n.flg.overflow_flag = 1'b0;
            n.arm.overflow_flag = 1'b0;
        end
        if ((i_rd || i_wr) && r.arm.second_capture_flag
            && (i_addr == ADR_CAP2_LO)) begin
            n.flg.second_capture_flag = 1'b0;
            n.arm.second_capture_flag = 1'b0;
        end
        if ((i_rd || i_wr) && r.arm.second_match_flag
            && (i_addr == ADR_CMP2_LO)) begin
            n.flg.second_match_flag = 1'b0;
            n.arm.second_match_flag = 1'b0;
        end

        // Register writes
        if (i_wr) begin
            unique case (i_addr)
                ADR_CTL_ONE: n.ctl1 = i_wdata;
                ADR_CTL_TWO: n.ctl2 = i_wdata;
                ADR_STATUS:  n.tdis = i_wdata[2];
                ADR_CMP1_HI: begin
                    n.cmp1[15:8] = i_wdata;
                    n.lock1      = 1'b1;
                end
                ADR_CMP1_LO: begin
                    n.cmp1[7:0] = i_wdata;
                    n.lock1     = 1'b0;
                end
                ADR_CMP2_HI: begin
                    n.cmp2[15:8] = i_wdata;
                    n.lock2      = 1'b1;
                end
                ADR_CMP2_LO: begin
                    n.cmp2[7:0] = i_wdata;
                    n.lock2     = 1'b0;
                end
                ADR_CNT_LO:  n.cnt = CNT_RESET;
                ADR_ALT_LO:  n.cnt = CNT_RESET;
                default:     n.pre = n.pre;
            endcase
        end

        // Shadows follow outside PWM; in PWM only at period end
        if (!pwm_on || m2) begin
            if (!r.lock1) begin
                n.sh1 = r.cmp1;
            end
            if (!r.lock2) begin
                n.sh2 = r.cmp2;
            end
        end

        // Counting
        if (tick) begin
            if (pwm_on && m2) begin
                n.cnt = CNT_RESET;
            end else begin
                n.cnt = r.cnt + 16'h0001;
                if (r.cnt == CNT_MAX) begin
                    n.flg.overflow_flag = 1'b1;
                end
            end
        end

        // Compare and waveform
        if (pwm_on) begin
            if (m1) begin
                n.pin1 = r.ctl1.first_output_level;
            end
            if (m2) begin
                n.pin1 = r.ctl1.second_output_level;
                n.flg.first_capture_flag = 1'b1;
            end
        end else if (single_on) begin
            if (m1) begin
                n.pin1 = r.ctl1.first_output_level;
            end
            if (m2) begin
                n.flg.second_match_flag = 1'b1;
            end
            if (cap1_ev && run) begin
                n.cap1 = r.cnt;
                n.cnt  = CNT_RESET;
                n.pin1 = r.ctl1.second_output_level;
                n.flg.first_capture_flag = 1'b1;
            end
        end else begin
            if (m1) begin
                n.pin1 = r.ctl1.first_output_level;
                n.flg.first_match_flag = 1'b1;
            end
            if (m2) begin
                n.pin2 = r.ctl1.second_output_level;
                n.flg.second_match_flag = 1'b1;
            end
            if (r.ctl1.force_first_output) begin
                n.pin1 = r.ctl1.first_output_level;
            end
            if (r.ctl1.force_second_output) begin
                n.pin2 = r.ctl1.second_output_level;
            end
            if (cap1_ev && run) begin
                n.cap1 = r.cnt;
                n.flg.first_capture_flag = 1'b1;
            end
        end

        // Capture 2 in all modes; capture pin 1 ignored in PWM
        if (cap2_ev && run) begin
            n.cap2 = r.cnt;
            n.flg.second_capture_flag = 1'b1;
        end

        // Halt: edges arm, capture taken at exit
        if (i_halt) begin
            if (cap1_ev && !pwm_on) begin
                n.harm[0] = 1'b1;
            end
            if (cap2_ev) begin
                n.harm[1] = 1'b1;
            end
        end
        if (halt_exit) begin
            n.harm = 2'h0;
            if (r.harm[0]) begin
                n.cap1 = r.cnt;
                n.flg.first_capture_flag = 1'b1;
            end
            if (r.harm[1]) begin
                n.cap2 = r.cnt;
                n.flg.second_capture_flag = 1'b1;
            end
        end

        // Pin enables
        n.oe1 = n.ctl2.first_compare_pin_enable && !n.tdis;
        n.oe2 = n.ctl2.second_compare_pin_enable && !n.tdis;

        // Shared request and wake from wait
        n.irq = !i_irq_mask && (
            (n.ctl1.capture_irq_enable
             && (n.flg.first_capture_flag
                 || n.flg.second_capture_flag))
            || (n.ctl1.match_irq_enable
                && (n.flg.first_match_flag
                    || n.flg.second_match_flag))
            || (n.ctl1.overflow_irq_enable
                && n.flg.overflow_flag));
        n.wwake = n.irq && i_wait && !i_halt;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r      <= '0;
            r.cnt  <= CNT_RESET;
            r.cmp1 <= CMP_RESET;
            r.cmp2 <= CMP_RESET;
            r.sh1  <= CMP_RESET;
            r.sh2  <= CMP_RESET;
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // Outputs
    always_comb begin
        o_rdata                 = r.rdata;
        o_first_compare_pin     = r.pin1;
        o_first_compare_pin_oe  = r.oe1;
        o_second_compare_pin    = r.pin2;
        o_second_compare_pin_oe = r.oe2;
        o_irq                   = r.irq;
        o_wait_wake             = r.wwake;
    end

    // ==========================================================
    // Checks
    a_pwm_no_match: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (pwm_on && !r.flg.first_match_flag && !r.flg.second_match_flag)
        |=> (!r.flg.first_match_flag && !r.flg.second_match_flag))
        else $error("match flag set in PWM");

    a_pwm_reload: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (pwm_on && m2 && !(i_wr && (i_addr == ADR_CNT_LO)))
        |=> (r.cnt == CNT_RESET))
        else $error("PWM period end did not reload counter");

    a_pwm_cap_flag: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (pwm_on && m2) |=> r.flg.first_capture_flag)
        else $error("PWM period end did not set capture flag 1");

    a_pwm_level: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (pwm_on && m2) |=> (r.pin1 == $past(r.ctl1.second_output_level)))
        else $error("PWM pin not at level 2 after period end");

    a_overflow_set: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (tick && (r.cnt == CNT_MAX) && !(pwm_on && m2))
        |=> r.flg.overflow_flag)
        else $error("overflow flag not set on roll-over");

    a_halt_freeze: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_halt && !i_wr) |=> (r.cnt == $past(r.cnt)))
        else $error("counter moved during halt");

    a_irq_gate: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        o_irq |-> !$past(i_irq_mask))
        else $error("interrupt raised while masked");

    a_cap1_edge: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (!pwm_on && run && r.ctl1.first_capture_edge_select && rise.cap1)
        |=> (r.flg.first_capture_flag && (r.cap1 == $past(r.cnt))))
        else $error("rising edge did not capture");

    a_force_out: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (!pwm_on && !single_on && r.ctl1.force_first_output && !i_wr)
        |=> (o_first_compare_pin == $past(r.ctl1.first_output_level)))
        else $error("forced level not on compare pin 1");

    a_read_ctl: assert property (
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_rd && (i_addr == ADR_CTL_ONE)) |=> (o_rdata == $past(r.ctl1)))
        else $error("control one read back wrong");

endmodule : tpw_timer

`default_nettype wire

/* testbench/tpw_pin_model.sv */
/*
 * Far-side pin model: capture pins, external clock, compare-1 line.
 * Assumes the bench asks for a capture-2 pulse with a one-cycle request.
 */
`timescale 1ns/1ps
`default_nettype none

module tpw_pin_model (
    // Clock and request
    input  wire logic i_clk_sys,
    input  wire logic i_pulse2,
    // Compare pin from the timer
    input  wire logic i_cmp1,
    input  wire logic i_cmp1_oe,
    // Pins to the timer
    output var  logic o_cap1,
    output var  logic o_cap2,
    output var  logic o_ext,
    // Resolved compare-1 line
    output var  logic o_line1
);
    // ==========================================================
    // Pins
    logic [3:0] low_cnt_r = 4'h0;

    always_ff @(posedge i_clk_sys) begin
        if (i_pulse2) begin
            low_cnt_r <= 4'h8;
        end else if (low_cnt_r != 4'h0) begin
            low_cnt_r <= low_cnt_r - 4'h1;
        end
    end

    assign o_cap1  = 1'b1;
    assign o_ext   = 1'b0;
    assign o_cap2  = (low_cnt_r == 4'h0);
    assign o_line1 = i_cmp1_oe ? i_cmp1 : 1'b1;
endmodule : tpw_pin_model

`default_nettype wire

/* testbench/tb.sv */
/*
 * Self-checking bench of the timer: registers, PWM, power states.
 * Assumes the pin model beside the design and a 10 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    import tpw_pkg::*;
    // ==========================================================
    // Signals
    logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, a, b;
    logic       wt = 1'b0, hl = 1'b0, msk = 1'b0, p2 = 1'b0;
    logic       c1, c2, ex, p1, oe1, q2, oe2, irq, wk, ln1;
    int         n_fail = 0, num_checks = 0, hi, lo, bad;

    tpw_timer dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_wait(wt), .i_halt(hl), .i_irq_mask(msk),
        .i_first_capture_pin(c1), .i_second_capture_pin(c2),
        .i_ext_clk(ex), .o_first_compare_pin(p1),
        .o_first_compare_pin_oe(oe1), .o_second_compare_pin(q2),
        .o_second_compare_pin_oe(oe2), .o_irq(irq), .o_wait_wake(wk));
    tpw_pin_model pins (.i_clk_sys(clk), .i_pulse2(p2), .i_cmp1(p1),
        .i_cmp1_oe(oe1), .o_cap1(c1), .o_cap2(c2), .o_ext(ex),
        .o_line1(ln1));

    initial begin
        forever #50 clk = ~clk;
    end

    // ==========================================================
    // Tasks
    task cyc(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask : cyc

    task wr_reg(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk);
        addr  <= ad;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [3:0] ad, output logic [7:0] d);
        @(posedge clk);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task endt(input string nm);
        $display("test %s finished", nm);
    endtask : endt

    // Capture-2 pin low for a few cycles, then time for the sync stages
    task pulse2;
        @(posedge clk);
        p2 <= 1'b1;
        @(posedge clk);
        p2 <= 1'b0;
        cyc(20);
    endtask : pulse2

    // Counter advance over 16 clocks for one clock select
    task rate(input string nm, input logic [7:0] cs, input logic [7:0] e);
        wr_reg(ADR_CTL_TWO, cs);
        rd_reg(ADR_CNT_LO, a);
        cyc(14);
        rd_reg(ADR_CNT_LO, b);
        chk(nm, e, 8'(b - a));
    endtask : rate

    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #1_000_000;
        n_fail++;
        print_verdict();
    end

    // ==========================================================
    // Tests
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(ADR_CNT_LO, a);
        chk("cnt lo reset", 8'hFC, a);
        rd_reg(ADR_CTL_ONE, a);
        chk("ctl1 reset", 8'h00, a);
        rd_reg(ADR_STATUS, a);
        chk("status reset", 8'h00, a);
        rd_reg(4'hF, a);
        chk("unmapped", 8'h00, a);
        wr_reg(ADR_CTL_ONE, 8'h81);
        rd_reg(ADR_CTL_ONE, a);
        chk("ctl1 rw", 8'h81, a);
        endt("registers");
        wr_reg(ADR_CMP1_HI, 8'h00);
        wr_reg(ADR_CMP1_LO, 8'h04);
        wr_reg(ADR_CMP2_HI, 8'h00);
        wr_reg(ADR_CMP2_LO, 8'h10);
        wr_reg(ADR_CTL_TWO, 8'hB4);
        bad = 0;
        while (irq !== 1'b1 && bad < 2000) begin
            cyc(1);
            bad++;
        end
        chk("irq period", 1'b1, irq);
        rd_reg(ADR_STATUS, a);
        chk("pwm flags", 8'hA0, a & 8'hF8);
        while (ln1 !== 1'b0 && hi < 200) begin
            cyc(1);
            hi++;
        end
        while (ln1 !== 1'b1 && lo < 200) begin
            cyc(1);
            lo++;
        end
        hi = 0;
        lo = 0;
        while (ln1 === 1'b1 && hi < 200) begin
            cyc(1);
            hi++;
        end
        while (ln1 === 1'b0 && lo < 200) begin
            cyc(1);
            lo++;
        end
        chk("pulse", 16'h0018, hi[15:0]);
        chk("period", 16'h002A, 16'(hi + lo));
        chk("pin1 oe", 1'b1, oe1);
        endt("pwm");
        @(posedge clk);
        msk <= 1'b1;
        cyc(3);
        chk("masked", 1'b0, irq);
        @(posedge clk);
        msk <= 1'b0;
        wt  <= 1'b1;
        rd_reg(ADR_CNT_LO, a);
        cyc(5);
        rd_reg(ADR_CNT_LO, b);
        chk("wait runs", 1'b1, a !== b);
        chk("wait wake", 1'b1, wk);
        pulse2();
        rd_reg(ADR_STATUS, a);
        chk("cap2 pwm", 8'h10, a & 8'h10);
        @(posedge clk);
        hl <= 1'b1;
        cyc(3);
        chk("halt no wake", 1'b0, wk);
        rd_reg(ADR_CNT_LO, a);
        cyc(10);
        rd_reg(ADR_CNT_LO, b);
        chk("halt frozen", a, b);
        pulse2();
        @(posedge clk);
        hl <= 1'b0;
        wt <= 1'b0;
        cyc(3);
        rd_reg(ADR_CAP2_LO, a);
        chk("halt capture", b, a);
        endt("power");
        wr_reg(ADR_CTL_ONE, 8'h85);
        cyc(60);
        bad = 0;
        repeat (50) begin
            cyc(1);
            if (ln1 !== 1'b1) begin
                bad++;
            end
        end
        chk("equal levels", 16'h0000, bad[15:0]);
        wr_reg(ADR_CTL_TWO, 8'hC4);
        wr_reg(ADR_CTL_ONE, 8'h1C);
        cyc(3);
        chk("force pins", 4'hB, {oe1, p1, oe2, q2});
        wr_reg(ADR_CTL_ONE, 8'h19);
        cyc(3);
        chk("force pins", 4'hE, {oe1, p1, oe2, q2});
        endt("force");
        rate("div8 rate", 8'h08, 8'h02);
        rate("div4 rate", 8'h00, 8'h04);
        rate("ext idle", 8'h0C, 8'h00);
        endt("clock");
        print_verdict();
    end
endmodule : tb

`default_nettype wire
